// ### hw/odslc_pkg.sv
// What this block does
// - A low load strobe copies input registers into converter registers.
// - A load pulse updates every converter holding new data at once.
// - A frame strobe fall powers the input buffers and arms the shifter.
// - After the strobe falls, one bit is taken on each of 16 clock falls.
// - A strobe rise before the 16th clock fall, in a cycle with no clock fall, aborts and drops the word.
// - The word is held in a 16-bit shift register, one bit per clock fall.
// - After each full write the input buffers sleep until the next frame.
// - Two shared references are each set buffered, unbuffered or supply.
// - Each converter code is straight binary, 0 to 4095 at twelve bits.
`default_nettype none
package odslc_pkg;
   localparam int WORD_BITS = 16;
   localparam int CODE_BITS = 12;
   localparam int CHANNELS = 8;
   localparam int CHAN_BITS = 3;
   localparam int SYNC_STAGES = 2;
   localparam logic [3:0] LAST_BIT_COUNT = 4'hF;
   // word layout: bit 15 selects data or control
   localparam int TYPE_POS = 15;
   localparam int CHAN_POS = 12;
   localparam int CODE_POS = 0;
   localparam int BUF_ABCD_POS = 0;
   localparam int BUF_EFGH_POS = 1;
   localparam int VDD_ABCD_POS = 2;
   localparam int VDD_EFGH_POS = 3;
   localparam int GROUP_SIZE = 4;
   // host side clock ceiling, kept for the bench
   localparam int SCLK_MAX_MHZ = 30;
   localparam int CLOCK_MHZ = 20;
   localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
   localparam logic [1:0] REF_UNBUFFERED = 2'h0;
   localparam logic [1:0] REF_BUFFERED = 2'h1;
   localparam logic [1:0] REF_SUPPLY = 2'h2;
   localparam logic [CHANNELS-1:0] MASK_NONE = 8'h00;
   typedef enum logic {ODSLC_IDLE, ODSLC_SHIFT} odslc_state_type;
endpackage
`default_nettype wire

// ### hw/odslc_top.sv
`timescale 1ns/1ps
`default_nettype none
module odslc_top (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   input wire logic SYNC_N,
   input wire logic SCLK,
   input wire logic DIN,
   input wire logic LOAD_STROBE_N,
   output logic [odslc_pkg::CHANNELS*odslc_pkg::CODE_BITS-1:0] DAC_CODE,
   output logic [1:0] REF_MODE_ABCD,
   output logic [1:0] REF_MODE_EFGH,
   output logic INPUT_BUF_EN,
   output logic WORD_DONE
);
   import odslc_pkg::*;

   logic [SYNC_STAGES-1:0] sync_n_s_q, sclk_s_q, din_s_q, load_n_s_q;
   logic [SYNC_STAGES-1:0] sync_n_s_d, sclk_s_d, din_s_d, load_n_s_d;
   logic sync_n_prev_q, sclk_prev_q, sync_n_prev_d, sclk_prev_d;
   odslc_state_type state_q, state_d;
   logic [WORD_BITS-1:0] shift_q, shift_d;
   logic [3:0] count_q, count_d;
   logic buf_en_q, buf_en_d;
   logic done_q, done_d;
   logic [CODE_BITS-1:0] input_q [CHANNELS];
   logic [CODE_BITS-1:0] input_d [CHANNELS];
   logic [CODE_BITS-1:0] conv_q [CHANNELS];
   logic [CODE_BITS-1:0] conv_d [CHANNELS];
   logic [CHANNELS-1:0] pending_q, pending_d, new_mask;
   logic buf_abcd_q, buf_efgh_q, vdd_abcd_q, vdd_efgh_q;
   logic buf_abcd_d, buf_efgh_d, vdd_abcd_d, vdd_efgh_d;
   logic [1:0] ref_abcd_q, ref_efgh_q, ref_abcd_d, ref_efgh_d;
   logic sync_fall, sync_rise, sclk_fall, load_active;
   logic [WORD_BITS-1:0] word;

   // supply bit beats buffer bit for a group
   function automatic logic [1:0] ref_mode(input logic buf_bit,
                                           input logic vdd_bit);
      if (vdd_bit)
         return REF_SUPPLY;
      else if (buf_bit)
         return REF_BUFFERED;
      else
         return REF_UNBUFFERED;
   endfunction

   // edge finders on the synchronised levels; the fall finder is shared by the frame strobe and the serial clock
   function automatic logic edge_fall(input logic prev,
                                      input logic cur);
      return prev & ~cur;
   endfunction

   function automatic logic edge_rise(input logic prev,
                                      input logic cur);
      return ~prev & cur;
   endfunction

   // channel field of a data word, read by store and mark alike
   function automatic logic [CHAN_BITS-1:0] chan_of(
      input logic [WORD_BITS-1:0] w);
      return w[CHAN_POS +: CHAN_BITS];
   endfunction

   // two-stage synchronisers; edge logic reads only the last stage
   always_comb begin
      sync_n_s_d = {sync_n_s_q[0], SYNC_N};
      sclk_s_d = {sclk_s_q[0], SCLK};
      din_s_d = {din_s_q[0], DIN};
      load_n_s_d = {load_n_s_q[0], LOAD_STROBE_N};
      sync_n_prev_d = sync_n_s_q[1];
      sclk_prev_d = sclk_s_q[1];
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sync_n_s_q <= '1;
         sclk_s_q <= '0;
         din_s_q <= '0;
         load_n_s_q <= '1;
         sync_n_prev_q <= 1'h1;
         sclk_prev_q <= 1'h0;
      end else if (CE) begin
         sync_n_s_q <= sync_n_s_d;
         sclk_s_q <= sclk_s_d;
         din_s_q <= din_s_d;
         load_n_s_q <= load_n_s_d;
         sync_n_prev_q <= sync_n_prev_d;
         sclk_prev_q <= sclk_prev_d;
      end
   end

   // strobe edges; load acts on its level, not an edge, so a strobe
   // tied low still copies every new word
   assign sync_fall = edge_fall(sync_n_prev_q, sync_n_s_q[1]);
   assign sync_rise = edge_rise(sync_n_prev_q, sync_n_s_q[1]);
   assign sclk_fall = edge_fall(sclk_prev_q, sclk_s_q[1]);
   assign load_active = ~load_n_s_q[1];

   // frame sequencer and shift register
   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      count_d = count_q;
      buf_en_d = buf_en_q;
      done_d = 1'h0;
      case (state_q)
         ODSLC_IDLE: begin
            if (sync_fall) begin
               state_d = ODSLC_SHIFT;
               count_d = 4'h0;
               buf_en_d = 1'h1;
            end
         end
         ODSLC_SHIFT: begin
            // a clock fall seen with the strobe rise still counts
            if (sclk_fall) begin
               shift_d = {shift_q[WORD_BITS-2:0], din_s_q[1]};
               count_d = count_q + 4'h1;
               if (count_q == LAST_BIT_COUNT) begin
                  state_d = ODSLC_IDLE;
                  buf_en_d = 1'h0;
                  done_d = 1'h1;
               end
            end else if (sync_rise) begin
               state_d = ODSLC_IDLE;
               buf_en_d = 1'h0;
            end
         end
         default: begin
            state_d = ODSLC_IDLE;
            buf_en_d = 1'h0;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_q <= ODSLC_IDLE;
         shift_q <= '0;
         count_q <= 4'h0;
         buf_en_q <= 1'h0;
         done_q <= 1'h0;
      end else if (CE) begin
         state_q <= state_d;
         shift_q <= shift_d;
         count_q <= count_d;
         buf_en_q <= buf_en_d;
         done_q <= done_d;
      end
   end

   // decode a finished word one cycle after its last bit
   assign word = shift_q;
   always_comb begin
      new_mask = MASK_NONE;
      buf_abcd_d = buf_abcd_q;
      buf_efgh_d = buf_efgh_q;
      vdd_abcd_d = vdd_abcd_q;
      vdd_efgh_d = vdd_efgh_q;
      for (int i = 0; i < CHANNELS; i++)
         input_d[i] = input_q[i];
      if (done_q) begin
         if (word[TYPE_POS]) begin
            buf_abcd_d = word[BUF_ABCD_POS];
            buf_efgh_d = word[BUF_EFGH_POS];
            vdd_abcd_d = word[VDD_ABCD_POS];
            vdd_efgh_d = word[VDD_EFGH_POS];
         end else begin
            // the code is kept as sent, straight binary
            input_d[chan_of(word)] = word[CODE_POS +: CODE_BITS];
            new_mask[chan_of(word)] = 1'h1;
         end
      end
      // mode kept decoded so the pins come straight from flops
      ref_abcd_d = ref_mode(buf_abcd_d, vdd_abcd_d);
      ref_efgh_d = ref_mode(buf_efgh_d, vdd_efgh_d);
   end

   // load copies only channels holding new data, including data decoded in the load cycle, then clears every pending bit
   always_comb begin
      pending_d = pending_q | new_mask;
      for (int i = 0; i < CHANNELS; i++)
         conv_d[i] = conv_q[i];
      if (load_active) begin
         for (int i = 0; i < CHANNELS; i++)
            if (pending_d[i])
               conv_d[i] = input_d[i];
         pending_d = MASK_NONE;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         for (int i = 0; i < CHANNELS; i++) begin
            input_q[i] <= CODE_RESET;
            conv_q[i] <= CODE_RESET;
         end
         pending_q <= MASK_NONE;
         buf_abcd_q <= 1'h0;
         buf_efgh_q <= 1'h0;
         vdd_abcd_q <= 1'h0;
         vdd_efgh_q <= 1'h0;
         ref_abcd_q <= REF_UNBUFFERED;
         ref_efgh_q <= REF_UNBUFFERED;
      end else if (CE) begin
         for (int i = 0; i < CHANNELS; i++) begin
            input_q[i] <= input_d[i];
            conv_q[i] <= conv_d[i];
         end
         pending_q <= pending_d;
         buf_abcd_q <= buf_abcd_d;
         buf_efgh_q <= buf_efgh_d;
         vdd_abcd_q <= vdd_abcd_d;
         vdd_efgh_q <= vdd_efgh_d;
         ref_abcd_q <= ref_abcd_d;
         ref_efgh_q <= ref_efgh_d;
      end
   end

   // outputs straight from flip-flops
   always_comb begin
      for (int i = 0; i < CHANNELS; i++)
         DAC_CODE[i*CODE_BITS +: CODE_BITS] = conv_q[i];
   end
   assign REF_MODE_ABCD = ref_abcd_q;
   assign REF_MODE_EFGH = ref_efgh_q;
   assign INPUT_BUF_EN = buf_en_q;
   assign WORD_DONE = done_q;
endmodule // odslc_top
`default_nettype wire

// ### testbench/odslc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module odslc_top_monitor (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   input wire logic SYNC_N,
   input wire logic SCLK,
   input wire logic DIN,
   input wire logic LOAD_STROBE_N,
   input wire logic [odslc_pkg::CHANNELS*odslc_pkg::CODE_BITS-1:0] DAC_CODE,
   input wire logic [1:0] REF_MODE_ABCD,
   input wire logic [1:0] REF_MODE_EFGH,
   input wire logic INPUT_BUF_EN,
   input wire logic WORD_DONE
);
   import odslc_pkg::*;
   // one domain; the enable freezes everything
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST || !CE);
   a_buf_arm: assert property (
      $fell(SYNC_N) |-> ##[2:5] INPUT_BUF_EN) else $error("buffers not armed");
   a_done_pulse: assert property (
      WORD_DONE |=> !WORD_DONE) else $error("done too long");
   a_done_ends: assert property (
      WORD_DONE |-> !INPUT_BUF_EN && $past(INPUT_BUF_EN))
      else $error("done without frame");
   a_abort_sync: assert property (
      $fell(INPUT_BUF_EN) && !WORD_DONE |-> SYNC_N) else $error("buffers off");
   a_idle_off: assert property (
      SYNC_N [*4] ##0 !INPUT_BUF_EN |=> !INPUT_BUF_EN)
      else $error("buffers on");
   a_code_cause: assert property (
      $changed(DAC_CODE) |-> !$past(LOAD_STROBE_N, 2)
      || !$past(LOAD_STROBE_N, 3) || !$past(LOAD_STROBE_N, 4))
      else $error("code moved without load");
   a_ref_cause: assert property (
      $changed({REF_MODE_ABCD, REF_MODE_EFGH}) |-> $past(WORD_DONE))
      else $error("reference mode moved");
   a_ref_legal: assert property (
      REF_MODE_ABCD != 2'h3 && REF_MODE_EFGH != 2'h3) else $error("bad mode");
endmodule // odslc_top_monitor
bind odslc_top odslc_top_monitor u_monitor (.CLOCK(CLOCK), .RST(RST), .CE(CE),
   .SYNC_N(SYNC_N), .SCLK(SCLK), .DIN(DIN), .LOAD_STROBE_N(LOAD_STROBE_N),
   .DAC_CODE(DAC_CODE), .REF_MODE_ABCD(REF_MODE_ABCD),
   .REF_MODE_EFGH(REF_MODE_EFGH), .INPUT_BUF_EN(INPUT_BUF_EN),
   .WORD_DONE(WORD_DONE));
`default_nettype wire

// ### testbench/odslc_host.sv
`timescale 1ns/1ps
`default_nettype none
module odslc_host (
   output logic sync_n,
   output logic sclk,
   output logic din
);
   // idle link: strobe high, clock parked high
   initial begin
      sync_n = 1'h1;
      sclk = 1'h1;
      din = 1'h0;
   end
   // msb first; 200 ns halves stay far below 30 MHz
   task automatic send(logic [15:0] w, int n);
      sync_n = 1'h0;
      for (int i = 15; i > 15 - n; i--) begin
         #200 sclk = 1'h1;
         din = w[i];
         #200 sclk = 1'h0;
      end
      #200 sclk = 1'h1;
      #200 sync_n = 1'h1;
      din = ~din; // data line inverted after the frame, still driven
   endtask
endmodule // odslc_host
`default_nettype wire

// ### testbench/tb_odslc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_odslc_top;
   import odslc_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic ld_n = 1'h1;
   logic ce = 1'h1;
   wire sy_n, sck, din, ben, done;
   wire [95:0] dac;
   wire [1:0] ra, re;
   logic [95:0] e_in = 96'h0;
   logic [95:0] e_dac = 96'h0;
   logic [7:0] pend = 8'h0;
   logic [3:0] e_ref = 4'h0;
   logic [15:0] w;
   int n_mismatch = 0;
   int checks_done = 0;
   int n_done = 0;
   odslc_host u_host (.sync_n(sy_n), .sclk(sck), .din(din));
   odslc_top u_dut (.CLOCK(clk), .RST(rst), .CE(ce), .SYNC_N(sy_n),
      .SCLK(sck), .DIN(din), .LOAD_STROBE_N(ld_n), .DAC_CODE(dac),
      .REF_MODE_ABCD(ra), .REF_MODE_EFGH(re), .INPUT_BUF_EN(ben),
      .WORD_DONE(done));
   initial forever #25 clk = ~clk;
   // done stands one cycle, so exactly one falling edge sees it
   always @(negedge clk) begin
      if (done === 1'h1) n_done++;
   end
   // model: a load copies only channels holding new data
   function automatic void load_model();
      for (int c = 0; c < 8; c++)
         if (pend[c]) e_dac[c*12 +: 12] = e_in[c*12 +: 12];
      pend = 8'h0;
   endfunction
   task automatic chk();
      checks_done++;
      if ({dac, ra, re} !== {e_dac, e_ref}) begin
         $display("Error %0t: outputs differ", $time);
         n_mismatch++;
      end
   endtask
   // short frames are aborts and must leave the model alone
   task automatic wr(int n);
      int d0;
      d0 = n_done;
      u_host.send(w, n);
      repeat (6) @(negedge clk);
      checks_done++;
      // one done pulse per whole frame, buffers off after any frame
      if (n_done != d0 + int'(n == 16) || ben !== 1'h0) begin
         $display("Error %0t: frame end wrong", $time);
         n_mismatch++;
      end
      if (n < 16) return;
      if (w[15]) e_ref = {w[2] ? 2'h2 : {1'h0, w[0]},
         w[3] ? 2'h2 : {1'h0, w[1]}};
      else begin
         e_in[w[14:12]*12 +: 12] = w[11:0];
         pend[w[14:12]] = 1'h1;
      end
      if (!ld_n) load_model();
   endtask
   task automatic pulse();
      ld_n = 1'h0;
      repeat (2) @(negedge clk);
      ld_n = 1'h1;
      repeat (5) @(negedge clk);
      load_model();
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // a run of 36 frames needs well under a millisecond
   initial begin
      #1000000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'hC52625D5));
      repeat (8) @(negedge clk);
      rst = 1'h0;
      repeat (4) @(negedge clk);
      chk();
      for (int i = 0; i < 36; i++) begin
         w = {1'h0, 3'($urandom), 12'($urandom)};
         if (i < 2) w[11:0] = i ? 12'hFFF : 12'h000;
         if (i % 4 == 3) w = {1'h1, 11'h0, 4'(i / 4)};
         if (i == 24) ld_n = 1'h0;
         wr(i % 7 == 5 ? 15 : 16);
         if (i == 10) begin
            // a frozen block must miss a load pulse and keep its data
            ce = 1'h0;
            ld_n = 1'h0;
            repeat (3) @(negedge clk);
            ld_n = 1'h1;
            repeat (3) @(negedge clk);
            ce = 1'h1;
            repeat (3) @(negedge clk);
            chk();
         end
         if (ld_n && $urandom % 2) pulse();
         chk();
         if (i == 30) begin
            // reset in mid-run returns every code and mode to zero
            rst = 1'h1;
            repeat (2) @(negedge clk);
            rst = 1'h0;
            e_in = 96'h0;
            e_dac = 96'h0;
            pend = 8'h0;
            e_ref = 4'h0;
            repeat (3) @(negedge clk);
            chk();
         end
      end
      print_verdict();
   end
endmodule // tb_odslc_top
`default_nettype wire
